// file: src/vsync_pkg.sv
// Package with timing constants and carrier types for the video sync port.
package vsync_pkg;

  // Default raster geometry in pixel clocks and lines.
  localparam int H_ACTIVE_DEF = 640;
  localparam int H_FRONT_DEF  = 16;
  localparam int H_SYNC_DEF   = 96;
  localparam int H_BACK_DEF   = 48;
  localparam int V_ACTIVE_DEF = 480;
  localparam int V_FRONT_DEF  = 10;
  localparam int V_SYNC_DEF   = 2;
  localparam int V_BACK_DEF   = 33;

  // Pixel clock divider: system clocks per pixel.
  localparam int PIX_DIV_DEF = 8;

  // Width of the pixel and line counters.
  localparam int CNT_W = 12;

  // Reset values of the pin drivers.
  localparam logic [7:0] RGB_RST = 8'h00;

  // Sync and blank group travelling together.
  typedef struct packed {
    logic hsync;
    logic vsync;
    logic horiz_blank_out;
    logic vert_blank_out;
  } timing_type;

  // Pixel colour triple.
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } rgb_type;

  // ROM access states.
  typedef enum logic [1:0] {
    ROM_IDLE,
    ROM_WAIT,
    ROM_DONE
  } rom_state_type;

endpackage

// file: src/sync_edge.sv
// Two-flop synchroniser with rising-edge detector for an outside level.
`timescale 1ns/1ps
module sync_edge
  import vsync_pkg::*;
(
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // Asynchronous level in, synchronised level and edge out.
  input  wire logic async_i,
  output logic      level_o,
  output logic      rise_o
);

  logic meta_q;   // First stage, read only by the second stage.
  logic sync_q;   // Second stage.
  logic prev_q;   // Delayed copy for edge detection.

  // Registers only; the edge logic reads stages two and three.
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_o = sync_q;
  assign rise_o  = sync_q & ~prev_q;

endmodule

// file: src/video_sync_rgb_rom_port.sv
// Video sync, blank and digital RGB port shared with a boot ROM interface.
`timescale 1ns/1ps
module video_sync_rgb_rom_port
  import vsync_pkg::*;
#(
  parameter int H_ACTIVE = H_ACTIVE_DEF,
  parameter int H_FRONT  = H_FRONT_DEF,
  parameter int H_SYNC   = H_SYNC_DEF,
  parameter int H_BACK   = H_BACK_DEF,
  parameter int V_ACTIVE = V_ACTIVE_DEF,
  parameter int V_FRONT  = V_FRONT_DEF,
  parameter int V_SYNC   = V_SYNC_DEF,
  parameter int V_BACK   = V_BACK_DEF,
  parameter int PIX_DIV  = PIX_DIV_DEF,
  parameter int ROM_WAIT_CYC = 4
)
(
  // Clock and reset.
  input  wire logic        CLK_SYS_I,
  input  wire logic        RSTN_I,
  // External sync inputs, asynchronous, active high.
  input  wire logic        HSYNC_IN_I,
  input  wire logic        VSYNC_IN_I,
  // Pixel data from the pipeline and digital output enable.
  input  wire logic [23:0] PIXEL_I,
  input  wire logic        RGB_EN_I,
  // General purpose values for red and green when RGB is off.
  input  wire logic [7:0]  GP_RED_I,
  input  wire logic [7:0]  GP_GREEN_I,
  output logic [7:0]       GP_BLUE_O,
  // ROM request side.
  input  wire logic        ROM_REQ_I,
  input  wire logic [15:0] ROM_ADDR_I,
  output logic             ROM_ACK_O,
  output logic [7:0]       ROM_DATA_O,
  // Sync and blank pins.
  output logic             HSYNC_O,
  output logic             VSYNC_O,
  output logic             HORIZ_BLANK_OUT_O,
  output logic             VERT_BLANK_OUT_O,
  output logic             COMPOSITE_SYNC_OUT_O,
  output logic             COMPOSITE_BLANK_OUT_O,
  // Digital RGB pins; blue is two-way.
  output logic [7:0]       RED_O,
  output logic [7:0]       GREEN_O,
  output logic [7:0]       BLUE_O,
  output logic             BLUE_OE_O,
  input  wire logic [7:0]  BLUE_I,
  // ROM select, active low.
  output logic             USE_ROM_N_O
);

  localparam int H_TOTAL = H_ACTIVE + H_FRONT + H_SYNC + H_BACK;
  localparam int V_TOTAL = V_ACTIVE + V_FRONT + V_SYNC + V_BACK;
  // Sync start and end positions and counter limits, counted from the start of active video.
  localparam logic [CNT_W-1:0] HS_BEG = CNT_W'(H_ACTIVE + H_FRONT);
  localparam logic [CNT_W-1:0] HS_END = CNT_W'(H_ACTIVE + H_FRONT + H_SYNC);
  localparam logic [CNT_W-1:0] VS_BEG = CNT_W'(V_ACTIVE + V_FRONT);
  localparam logic [CNT_W-1:0] VS_END = CNT_W'(V_ACTIVE + V_FRONT + V_SYNC);
  localparam logic [CNT_W-1:0] H_LAST = CNT_W'(H_TOTAL - 1);
  localparam logic [CNT_W-1:0] V_LAST = CNT_W'(V_TOTAL - 1);
  localparam logic [CNT_W-1:0] H_ACT  = CNT_W'(H_ACTIVE);
  localparam logic [CNT_W-1:0] V_ACT  = CNT_W'(V_ACTIVE);
  localparam logic [7:0]  DIV_LAST = 8'(PIX_DIV - 1);
  localparam logic [7:0]  ROM_LAST = 8'(ROM_WAIT_CYC - 1);

  // Synchronised external sync edges and blue pin synchroniser stages.
  logic hs_rise;             // Horizontal sync in, rising edge.
  logic vs_rise;             // Vertical sync in, rising edge.
  logic [7:0] blue_meta_q;   // Blue pin first stage.
  logic [7:0] blue_sync_q;   // Blue pin second stage.

  sync_edge u_hs (
    .clk_i   (CLK_SYS_I),
    .rstn_i  (RSTN_I),
    .async_i (HSYNC_IN_I),
    .level_o (),
    .rise_o  (hs_rise)
  );

  sync_edge u_vs (
    .clk_i   (CLK_SYS_I),
    .rstn_i  (RSTN_I),
    .async_i (VSYNC_IN_I),
    .level_o (),
    .rise_o  (vs_rise)
  );

  // Raster counters and divider.
  logic [7:0]       div_q, div_d;   // Pixel clock divider.
  logic [CNT_W-1:0] h_q, h_d;       // Pixel counter.
  logic [CNT_W-1:0] v_q, v_d;       // Line counter.
  timing_type       tim_q, tim_d;   // Registered sync and blank.

  // ROM access state.
  rom_state_type state_q, state_d;  // Access state.
  logic [7:0]    wait_q, wait_d;    // Access time counter.
  logic [15:0]   addr_q, addr_d;    // Latched ROM address.
  logic [7:0]    rdata_q, rdata_d;  // Captured ROM byte.
  logic          ack_q, ack_d;      // Completion pulse.

  // Output pin registers.
  logic [7:0] red_q, red_d;         // Red pins.
  logic [7:0] grn_q, grn_d;         // Green pins.
  logic [7:0] blu_q, blu_d;         // Blue pins when driven.
  logic       boe_q, boe_d;         // Blue output enable.
  logic       rom_n_q, rom_n_d;     // ROM select.
  logic       composite_sync_out_q, composite_sync_out_d;     // Composite sync.
  logic       composite_blank_out_q, composite_blank_out_d;   // Composite blank.

  // Raster next state. An external sync edge resets the counter to the
  // position where our own sync starts, so both rasters line up.
  always_comb
  begin
    div_d = div_q;
    h_d   = h_q;
    v_d   = v_q;
    if (div_q == DIV_LAST)
    begin
      div_d = 8'h00;
      if (h_q == H_LAST)
      begin
        h_d = '0;
        v_d = (v_q == V_LAST) ? '0 : v_q + 1'b1;
      end
      else
      begin
        h_d = h_q + 1'b1;
      end
    end
    else
    begin
      div_d = div_q + 8'h01;
    end
    if (hs_rise)
    begin
      h_d   = HS_BEG;
      div_d = 8'h00;
    end
    if (vs_rise)
    begin
      v_d = VS_BEG;
    end
    // Sync and blank decoded from the next counter values.
    tim_d.hsync  = (h_d >= HS_BEG) && (h_d < HS_END);
    tim_d.vsync  = (v_d >= VS_BEG) && (v_d < VS_END);
    tim_d.horiz_blank_out = (h_d >= H_ACT);
    tim_d.vert_blank_out = (v_d >= V_ACT);
    composite_sync_out_d  = tim_d.hsync | tim_d.vsync;
    composite_blank_out_d = tim_d.horiz_blank_out | tim_d.vert_blank_out;
  end

  // Raster registers.
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      div_q    <= 8'h00;
      h_q      <= '0;
      v_q      <= '0;
      tim_q    <= '0;
      composite_sync_out_q  <= 1'b0;
      composite_blank_out_q <= 1'b0;
    end
    else
    begin
      div_q    <= div_d;
      h_q      <= h_d;
      v_q      <= v_d;
      tim_q    <= tim_d;
      composite_sync_out_q  <= composite_sync_out_d;
      composite_blank_out_q <= composite_blank_out_d;
    end
  end

  // ROM access and pin mux next state. A request is taken only in idle;
  // the ROM gets ROM_WAIT_CYC clocks of select before the byte is caught.
  always_comb
  begin
    state_d = state_q;
    wait_d  = wait_q;
    addr_d  = addr_q;
    rdata_d = rdata_q;
    ack_d   = 1'b0;
    case (state_q)
      ROM_IDLE:
      begin
        if (ROM_REQ_I)
        begin
          addr_d  = ROM_ADDR_I;
          wait_d  = 8'h00;
          state_d = ROM_WAIT;
        end
      end
      ROM_WAIT:
      begin
        if (wait_q == ROM_LAST)
        begin
          rdata_d = blue_sync_q;
          ack_d   = 1'b1;
          state_d = ROM_DONE;
        end
        else
        begin
          wait_d = wait_q + 8'h01;
        end
      end
      ROM_DONE:
      begin
        // One idle cycle lets the ROM float before RGB drives again.
        state_d = ROM_IDLE;
      end
      default:
      begin
        state_d = ROM_IDLE;
      end
    endcase
    // Pin multiplexer.
    if (state_d == ROM_WAIT)
    begin
      red_d   = addr_d[15:8];
      grn_d   = addr_d[7:0];
      blu_d   = RGB_RST;
      boe_d   = 1'b0;
      rom_n_d = 1'b0;
    end
    else if (RGB_EN_I && state_d == ROM_IDLE)
    begin
      red_d   = composite_blank_out_d ? RGB_RST : PIXEL_I[23:16];
      grn_d   = composite_blank_out_d ? RGB_RST : PIXEL_I[15:8];
      blu_d   = composite_blank_out_d ? RGB_RST : PIXEL_I[7:0];
      boe_d   = 1'b1;
      rom_n_d = 1'b1;
    end
    else
    begin
      red_d   = GP_RED_I;
      grn_d   = GP_GREEN_I;
      blu_d   = RGB_RST;
      boe_d   = 1'b0;
      rom_n_d = 1'b1;
    end
  end

  // ROM and pin registers; the blue pin passes two flops before use.
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      state_q     <= ROM_IDLE;
      wait_q      <= 8'h00;
      addr_q      <= 16'h0000;
      rdata_q     <= 8'h00;
      ack_q       <= 1'b0;
      red_q       <= RGB_RST;
      grn_q       <= RGB_RST;
      blu_q       <= RGB_RST;
      boe_q       <= 1'b0;
      rom_n_q     <= 1'b1;
      blue_meta_q <= 8'h00;
      blue_sync_q <= 8'h00;
    end
    else
    begin
      state_q     <= state_d;
      wait_q      <= wait_d;
      addr_q      <= addr_d;
      rdata_q     <= rdata_d;
      ack_q       <= ack_d;
      red_q       <= red_d;
      grn_q       <= grn_d;
      blu_q       <= blu_d;
      boe_q       <= boe_d;
      rom_n_q     <= rom_n_d;
      blue_meta_q <= BLUE_I;
      blue_sync_q <= blue_meta_q;
    end
  end

  // Output drive.
  assign HSYNC_O               = tim_q.hsync;
  assign VSYNC_O               = tim_q.vsync;
  assign HORIZ_BLANK_OUT_O     = tim_q.horiz_blank_out;
  assign VERT_BLANK_OUT_O      = tim_q.vert_blank_out;
  assign COMPOSITE_SYNC_OUT_O  = composite_sync_out_q;
  assign COMPOSITE_BLANK_OUT_O = composite_blank_out_q;
  assign RED_O                 = red_q;
  assign GREEN_O               = grn_q;
  assign BLUE_O                = blu_q;
  assign BLUE_OE_O             = boe_q;
  assign USE_ROM_N_O           = rom_n_q;
  assign ROM_ACK_O             = ack_q;
  assign ROM_DATA_O            = rdata_q;
  assign GP_BLUE_O             = blue_sync_q;

endmodule

// file: sim/boot_rom_model.sv
// Behavioural boot ROM that answers on the shared digital RGB pins.
`timescale 1ns/1ps
module boot_rom_model
(
  // Select and address from the port, byte back on blue.
  input  wire logic       sel_n_i,
  input  wire logic [7:0] hi_i,
  input  wire logic [7:0] lo_i,
  output logic      [7:0] data_o
);
  logic [7:0] last_q;  // Last byte this ROM put on the bus.

  // While selected the byte is a scramble of the address; once released
  // the bus shows the inverse of that byte, so stale sampling shows up.
  always @*
  begin
    if (!sel_n_i)
      last_q = lo_i ^ {hi_i[3:0], hi_i[7:4]};
    data_o = sel_n_i ? ~last_q : last_q;
  end
endmodule

// file: sim/vport_properties.sv
// Checker for the sync, blank and ROM pins of the video port.
`timescale 1ns/1ps
module vport_props
(
  input wire logic        CLK_SYS_I,
  input wire logic        RSTN_I,
  input wire logic        HSYNC_IN_I,
  input wire logic        VSYNC_IN_I,
  input wire logic        RGB_EN_I,
  input wire logic [7:0]  GP_RED_I,
  input wire logic [15:0] ROM_ADDR_I,
  input wire logic        ROM_ACK_O,
  input wire logic        HSYNC_O,
  input wire logic        VSYNC_O,
  input wire logic        HORIZ_BLANK_OUT_O,
  input wire logic        VERT_BLANK_OUT_O,
  input wire logic        COMPOSITE_SYNC_OUT_O,
  input wire logic        COMPOSITE_BLANK_OUT_O,
  input wire logic [7:0]  RED_O,
  input wire logic [7:0]  GREEN_O,
  input wire logic        BLUE_OE_O,
  input wire logic        USE_ROM_N_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);

  chk_composite_sync_out_or: assert property (
    COMPOSITE_SYNC_OUT_O == (HSYNC_O | VSYNC_O)) else $error("composite_sync_out bad");
  chk_composite_blank_out_or: assert property (
    COMPOSITE_BLANK_OUT_O == (HORIZ_BLANK_OUT_O | VERT_BLANK_OUT_O))
    else $error("composite_blank_out bad");
  chk_hsync_align: assert property (
    $rose(HSYNC_IN_I) |-> ##[1:6] HSYNC_O) else $error("no h realign");
  chk_vsync_align: assert property (
    $rose(VSYNC_IN_I) |-> ##[1:6] VSYNC_O) else $error("no v realign");
  chk_rom_addr: assert property (
    $fell(USE_ROM_N_O) |-> RED_O == $past(ROM_ADDR_I[15:8])
      && GREEN_O == $past(ROM_ADDR_I[7:0])) else $error("rom addr bad");
  chk_blue_release: assert property (
    !USE_ROM_N_O |-> !BLUE_OE_O) else $error("blue driven in rom read");
  chk_select_len: assert property (
    $fell(USE_ROM_N_O) |-> !USE_ROM_N_O [*4] ##1 USE_ROM_N_O)
    else $error("select length bad");
  chk_ack_end: assert property (
    $rose(USE_ROM_N_O) |-> ROM_ACK_O) else $error("ack not at select end");
  chk_gp_red: assert property (
    USE_ROM_N_O && $past(USE_ROM_N_O) && $past(RSTN_I) && !$past(RGB_EN_I)
      |-> RED_O == $past(GP_RED_I)) else $error("gp red bad");
endmodule

bind video_sync_rgb_rom_port vport_props u_chk (.*);

// file: sim/video_sync_rgb_rom_port_bench.sv
// Self-checking bench for the video sync and ROM port.
`timescale 1ns/1ps
module video_sync_rgb_rom_port_bench;
  import vsync_pkg::*;
  localparam int HACT = 8, HFRT = 2, HSYN = 2, HBCK = 2;  // Pixels.
  localparam int VACT = 4, VFRT = 1, VSYN = 1, VBCK = 1;  // Lines.
  localparam int PDIV = 2;  // System clocks per pixel.
  localparam int LN = 28;  // Cycles per line: 14 pixels of 2 clocks.
  logic [23:0] pix = 24'h123456;  // Pixel data from the pipeline.
  logic        clk = 0, rstn = 0, hs_in = 0, vs_in = 0, rgb_en = 0, req = 0;
  logic [7:0]  gp_r = 8'h00, gp_g = 8'h00, gp_b = 8'h00;
  logic [15:0] addr = 16'h0000;
  logic        ack, hs, vs, hb, vb, cs, cb, oe, sel_n;
  logic [7:0]  gp_bo, rdata, r, g, b, rom_d, blue;
  int          errors = 0, n_checks = 0;

  // Blue pin: port drives when enabled, else a selected ROM, the floating
  // ROM bus while RGB is in use, or the outside input.
  assign blue = oe ? b : ((!sel_n || rgb_en) ? rom_d : gp_b);

  initial forever #2.5 clk = ~clk;

  video_sync_rgb_rom_port #(.H_ACTIVE(HACT), .H_FRONT(HFRT),
    .H_SYNC(HSYN), .H_BACK(HBCK), .V_ACTIVE(VACT), .V_FRONT(VFRT),
    .V_SYNC(VSYN), .V_BACK(VBCK), .PIX_DIV(PDIV)) uut (.CLK_SYS_I(clk),
    .RSTN_I(rstn), .HSYNC_IN_I(hs_in),
    .VSYNC_IN_I(vs_in), .PIXEL_I(pix), .RGB_EN_I(rgb_en),
    .GP_RED_I(gp_r), .GP_GREEN_I(gp_g), .GP_BLUE_O(gp_bo), .ROM_REQ_I(req),
    .ROM_ADDR_I(addr), .ROM_ACK_O(ack), .ROM_DATA_O(rdata), .HSYNC_O(hs),
    .VSYNC_O(vs), .HORIZ_BLANK_OUT_O(hb), .VERT_BLANK_OUT_O(vb),
    .COMPOSITE_SYNC_OUT_O(cs), .COMPOSITE_BLANK_OUT_O(cb), .RED_O(r),
    .GREEN_O(g), .BLUE_O(b), .BLUE_OE_O(oe), .BLUE_I(blue),
    .USE_ROM_N_O(sel_n));

  boot_rom_model rom (.sel_n_i(sel_n), .hi_i(r), .lo_i(g), .data_o(rom_d));

  // Compares one value and counts it.
  task automatic check(string nm, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (exp !== got)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Holds one ROM request until the ack is seen, then checks the byte.
  task automatic rom_read(logic [15:0] a);
    int k;
    @(negedge clk);
    addr = a;
    req = 1;
    for (k = 0; k < 20 && ack !== 1'b1; k++)
      @(negedge clk);
    req = 0;
    check("rom ack", 1, k < 20);
    if (k >= 20)
      finish_test();
    check("rom byte", a[7:0] ^ {a[11:8], a[15:12]}, rdata);
  endtask

  // Pins as general outputs and blue as a general input.
  task automatic gp_test();
    rgb_en = 0;
    gp_r = 8'h3c;
    gp_g = 8'hc3;
    gp_b = 8'h96;
    repeat (5) @(negedge clk);
    check("red gp", 8'h3c, r);
    check("green gp", 8'hc3, g);
    check("blue oe", 0, oe);
    check("blue gp", 8'h96, gp_bo);
    // A ROM access must also work while digital RGB is off.
    rom_read(16'h0f5a);
    check("blue oe off", 0, oe);
  endtask

  // Back-to-back ROM reads while RGB output is in use.
  task automatic rom_test();
    rgb_en = 1;
    rom_read(16'ha53c);
    rom_read(16'h5ac3);
    rom_read(16'hff00);
    repeat (3) @(negedge clk);
    check("select idle", 1, sel_n);
    check("blue driven", 1, oe);
  endtask

  // Pixel data reaches the pins in active video and is dark in blank.
  task automatic pixel_test();
    int k;
    pix = 24'ha1b2c3;
    @(negedge clk);
    for (k = 0; k < 200 && cb !== 1'b0; k++)
      @(negedge clk);
    check("active found", 1, k < 200);
    if (k >= 200)
      finish_test();
    check("red pixel", 8'ha1, r);
    check("green pixel", 8'hb2, g);
    check("blue pixel", 8'hc3, b);
    for (k = 0; k < 200 && cb !== 1'b1; k++)
      @(negedge clk);
    check("blank found", 1, k < 200);
    if (k >= 200)
      finish_test();
    check("red blank", 8'h00, r);
    check("green blank", 8'h00, g);
    check("blue blank", 8'h00, b);
    check("blue oe blank", 1, oe);
  endtask

  // External sync edges realign the raster.
  task automatic sync_test();
    int k;
    hs_in = 1;
    vs_in = 1;
    for (k = 0; k < 8 && !(hs === 1'b1 && vs === 1'b1); k++)
      @(negedge clk);
    // Two sync flops and the output register; the edge decode is combinational.
    check("realign cycles", 3, k);
    if (k >= 8)
      finish_test();
    repeat (10) @(negedge clk);
    hs_in = 0;
    vs_in = 0;
  endtask

  // Counts sync and blank cycles over exactly one frame.
  task automatic frame_test();
    int n_hb, n_vb, n_hs, n_vs, n_cs, n_cb;
    {n_hb, n_vb, n_hs, n_vs, n_cs, n_cb} = '0;
    repeat (7 * LN)
    begin
      @(negedge clk);
      n_hb += hb;
      n_vb += vb;
      n_hs += hs;
      n_vs += vs;
      n_cs += cs;
      n_cb += cb;
    end
    check("horiz_blank_out", 7 * 12, n_hb[15:0]);
    check("vert_blank_out", 3 * LN, n_vb[15:0]);
    check("hsync", 7 * 4, n_hs[15:0]);
    check("vsync", LN, n_vs[15:0]);
    check("composite_sync_out", LN + 7 * 4 - 4, n_cs[15:0]);
    check("composite_blank_out", 2 * 84 - 3 * 12, n_cb[15:0]);
  endtask

  initial
  begin
    repeat (6) @(negedge clk);
    rstn = 1;
    gp_test();
    rom_test();
    pixel_test();
    sync_test();
    repeat (40) @(negedge clk);
    frame_test();
    finish_test();
  end
endmodule
